// [exacc_flow.sv]
`timescale 1ns/1ps
`default_nettype none
module exacc_flow
    import exacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic variant_mrpin,
    input wire logic reset_pin_n,
    input wire logic reset_kind_select_pin,
    input wire logic manual_reset_pin_n,
    input wire logic wdt_overflow,
    input wire logic watchdog_timer_mode_bit,
    input wire logic overflow_reset_select_bit,
    input wire exacc_req_t gen_req [NSRC],
    input wire logic [31:0] cur_pc,
    input wire logic user_break,
    input wire logic irq_req,
    input wire logic [11:0] irq_code,
    input wire logic nmi_req,
    input wire logic nmi_accept_blocked,
    input wire logic return_from_exception_op,
    input wire logic sw_sr_we,
    input wire exacc_sr_t sw_sr_wdata,
    input wire logic [31:0] exc_offset,
    output exacc_sr_t processor_status_word,
    output logic [31:0] vector_base,
    output logic [31:0] saved_program_counter,
    output exacc_sr_t saved_status_copy,
    output logic [11:0] exception_event_code,
    output logic [11:0] interrupt_event_code,
    output logic branch_valid,
    output logic [31:0] branch_target,
    output logic init_core,
    output logic init_periph_power_on,
    output logic init_periph_manual,
    output logic [SRC_W-1:0] accepted_src,
    output logic gen_accepted,
    output logic irq_accepted,
    output logic nmi_accepted
);
    logic rst_pin_n_s;
    logic sel_s;
    logic mrst_n_s;
    logic gen_any;
    logic [SRC_W-1:0] gen_sel;

    exacc_rstsrc u_rstsrc (
        .mclk(mclk),
        .rst(rst),
        .variant_mrpin(variant_mrpin),
        .reset_pin_n(reset_pin_n),
        .reset_kind_select_pin(reset_kind_select_pin),
        .manual_reset_pin_n(manual_reset_pin_n),
        .rst_pin_n_s(rst_pin_n_s),
        .sel_s(sel_s),
        .mrst_n_s(mrst_n_s)
    );

    exacc_pick #(.N(NSRC)) u_pick (
        .req(gen_req),
        .any(gen_any),
        .sel(gen_sel)
    );

    exacc_sr_t sr_r, sr_nxt;
    exacc_sr_t ssr_r, ssr_nxt;
    logic [31:0] spc_r, spc_nxt;
    logic [31:0] vbr_r, vbr_nxt;
    logic [11:0] exception_event_code_r, exception_event_code_nxt;
    logic [11:0] interrupt_event_code_r, interrupt_event_code_nxt;
    logic br_r, br_nxt;
    logic [31:0] tgt_r, tgt_nxt;
    exacc_rst_t kind_r, kind_nxt;
    logic [SRC_W-1:0] asrc_r, asrc_nxt;
    logic gacc_r, gacc_nxt;
    logic iacc_r, iacc_nxt;
    logic nacc_r, nacc_nxt;

    logic por_cond;
    logic man_cond;
    logic nest_exc;

    always_comb begin
        // Reset sources: pins, watchdog and nested exceptions
        por_cond = (!rst_pin_n_s && sel_s)
            || (wdt_overflow && watchdog_timer_mode_bit && !overflow_reset_select_bit);
        nest_exc = gen_any && sr_r.bl && !user_break;
        man_cond = (!rst_pin_n_s && !sel_s)
            || (!mrst_n_s && rst_pin_n_s)
            || (wdt_overflow && watchdog_timer_mode_bit && overflow_reset_select_bit)
            || nest_exc;

        sr_nxt = sr_r;
        ssr_nxt = ssr_r;
        spc_nxt = spc_r;
        vbr_nxt = vbr_r;
        exception_event_code_nxt = exception_event_code_r;
        interrupt_event_code_nxt = interrupt_event_code_r;
        br_nxt = 1'b0;
        tgt_nxt = tgt_r;
        kind_nxt = EXACC_RST_NONE;
        asrc_nxt = asrc_r;
        gacc_nxt = 1'b0;
        iacc_nxt = 1'b0;
        nacc_nxt = 1'b0;

        // Resets outrank everything; power-on wins a tie
        if (por_cond || man_cond) begin
            kind_nxt = por_cond ? EXACC_RST_POWER : EXACC_RST_MANUAL;
            exception_event_code_nxt = por_cond ? CODE_POWER_ON : CODE_MANUAL;
            vbr_nxt = VBR_RESET;
            sr_nxt = SR_RESET;
            br_nxt = 1'b1;
            tgt_nxt = RESET_VECTOR;
        end else if (gen_any && !sr_r.bl) begin
            // Decode-detected ones share one rank, program order picks
            asrc_nxt = gen_sel;
            gacc_nxt = 1'b1;
            spc_nxt = cur_pc;
            ssr_nxt = sr_r;
            exception_event_code_nxt = gen_req[gen_sel].code;
            sr_nxt.md = 1'b1;
            sr_nxt.rb = 1'b1;
            sr_nxt.bl = 1'b1;
            br_nxt = 1'b1;
            tgt_nxt = vbr_r + exc_offset;
        end else if (nmi_req && (!sr_r.bl || !nmi_accept_blocked)) begin
            nacc_nxt = 1'b1;
            spc_nxt = cur_pc;
            ssr_nxt = sr_r;
            interrupt_event_code_nxt = irq_code;
            sr_nxt.md = 1'b1;
            sr_nxt.rb = 1'b1;
            sr_nxt.bl = 1'b1;
            br_nxt = 1'b1;
            tgt_nxt = vbr_r + exc_offset;
        end else if (irq_req && !sr_r.bl) begin
            // Requester keeps the level up, so blocked ones stay pending
            iacc_nxt = 1'b1;
            spc_nxt = cur_pc;
            ssr_nxt = sr_r;
            interrupt_event_code_nxt = irq_code;
            sr_nxt.md = 1'b1;
            sr_nxt.rb = 1'b1;
            sr_nxt.bl = 1'b1;
            br_nxt = 1'b1;
            tgt_nxt = vbr_r + exc_offset;
        end else if (return_from_exception_op) begin
            // Software must set block bit first if the copies were spilled
            sr_nxt = ssr_r;
            br_nxt = 1'b1;
            tgt_nxt = spc_r;
        end else if (sw_sr_we) begin
            sr_nxt = sw_sr_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sr_r <= SR_RESET;
            ssr_r <= '0;
            spc_r <= '0;
            vbr_r <= VBR_RESET;
            exception_event_code_r <= CODE_POWER_ON;
            interrupt_event_code_r <= '0;
            br_r <= 1'b0;
            tgt_r <= RESET_VECTOR;
            kind_r <= EXACC_RST_NONE;
            asrc_r <= '0;
            gacc_r <= 1'b0;
            iacc_r <= 1'b0;
            nacc_r <= 1'b0;
        end else begin
            sr_r <= sr_nxt;
            ssr_r <= ssr_nxt;
            spc_r <= spc_nxt;
            vbr_r <= vbr_nxt;
            exception_event_code_r <= exception_event_code_nxt;
            interrupt_event_code_r <= interrupt_event_code_nxt;
            br_r <= br_nxt;
            tgt_r <= tgt_nxt;
            kind_r <= kind_nxt;
            asrc_r <= asrc_nxt;
            gacc_r <= gacc_nxt;
            iacc_r <= iacc_nxt;
            nacc_r <= nacc_nxt;
        end
    end

    assign processor_status_word = sr_r;
    assign vector_base = vbr_r;
    assign saved_program_counter = spc_r;
    assign saved_status_copy = ssr_r;
    assign exception_event_code = exception_event_code_r;
    assign interrupt_event_code = interrupt_event_code_r;
    assign branch_valid = br_r;
    assign branch_target = tgt_r;
    assign init_core = (kind_r != EXACC_RST_NONE);
    assign init_periph_power_on = (kind_r == EXACC_RST_POWER);
    assign init_periph_manual = (kind_r == EXACC_RST_MANUAL);
    assign accepted_src = asrc_r;
    assign gen_accepted = gacc_r;
    assign irq_accepted = iacc_r;
    assign nmi_accepted = nacc_r;

    chk_nest_manual: assert property (@(posedge mclk) disable iff (rst)
        (nest_exc && !por_cond) |=> (exception_event_code_r == CODE_MANUAL && tgt_r == RESET_VECTOR && br_r))
        else $error("nested exception did not give manual reset");
    chk_por_code: assert property (@(posedge mclk) disable iff (rst)
        por_cond |=> (exception_event_code_r == CODE_POWER_ON && init_periph_power_on && br_r))
        else $error("power-on reset code or branch wrong");
    chk_reset_init: assert property (@(posedge mclk) disable iff (rst)
        init_core |-> (sr_r == SR_RESET && vbr_r == VBR_RESET))
        else $error("reset initialisation wrong");
    chk_man_code: assert property (@(posedge mclk) disable iff (rst)
        init_periph_manual |-> (exception_event_code_r == CODE_MANUAL && tgt_r == RESET_VECTOR))
        else $error("manual reset code wrong");
    chk_irq_blocked: assert property (@(posedge mclk) disable iff (rst)
        $past(sr_r.bl) |-> !irq_accepted)
        else $error("interrupt accepted under block bit");
    chk_gen_blocked: assert property (@(posedge mclk) disable iff (rst)
        (gen_any && !sr_r.bl && !por_cond && !man_cond) |=> (gen_accepted && sr_r.bl))
        else $error("general exception not accepted");
    chk_rte_restore: assert property (@(posedge mclk) disable iff (rst)
        (return_from_exception_op && !por_cond && !man_cond && !gen_any && !nmi_req
            && !(irq_req && !sr_r.bl))
        |=> (sr_r == $past(ssr_r) && tgt_r == $past(spc_r) && br_r))
        else $error("return did not restore state");
    chk_por_wins: assert property (@(posedge mclk) disable iff (rst)
        (por_cond && man_cond) |=> init_periph_power_on)
        else $error("manual reset won over power-on");
    chk_wdt_manual: assert property (@(posedge mclk) disable iff (rst)
        (wdt_overflow && watchdog_timer_mode_bit && overflow_reset_select_bit && !por_cond)
        |=> init_periph_manual)
        else $error("watchdog manual reset missing");

    // Pin and watchdog sources each reach the right reset kind
    chk_por_pin: assert property (@(posedge mclk) disable iff (rst)
        (!rst_pin_n_s && sel_s) |=> init_periph_power_on)
        else $error("reset pin did not give power-on reset");
    chk_wdt_por: assert property (@(posedge mclk) disable iff (rst)
        (wdt_overflow && watchdog_timer_mode_bit && !overflow_reset_select_bit)
        |=> init_periph_power_on)
        else $error("watchdog power-on reset missing");
    chk_man_select: assert property (@(posedge mclk) disable iff (rst)
        (!rst_pin_n_s && !sel_s && !por_cond) |=> init_periph_manual)
        else $error("select and reset pins did not give manual reset");
    chk_man_pin: assert property (@(posedge mclk) disable iff (rst)
        (!mrst_n_s && rst_pin_n_s && !por_cond) |=> init_periph_manual)
        else $error("manual pin did not give manual reset");
    chk_reset_starts: assert property (@(posedge mclk) disable iff (rst)
        (por_cond || man_cond) |=> init_core)
        else $error("reset condition without core initialisation");
    chk_reset_vector: assert property (@(posedge mclk) disable iff (rst)
        init_core |-> (br_r && tgt_r == RESET_VECTOR))
        else $error("reset did not branch to the reset vector");
    chk_user_break: assert property (@(posedge mclk) disable iff (rst)
        (gen_any && sr_r.bl && user_break && !por_cond && !man_cond) |=> !init_core)
        else $error("user break under block bit gave a reset");

    // Acceptance: one event per cycle, context saved, codes in the right register
    chk_one_event: assert property (@(posedge mclk) disable iff (rst)
        $onehot0({init_core, gen_accepted, irq_accepted, nmi_accepted}))
        else $error("more than one event taken in a cycle");
    chk_gen_src: assert property (@(posedge mclk) disable iff (rst)
        (gen_any && !sr_r.bl && !por_cond && !man_cond) |=> accepted_src == $past(gen_sel))
        else $error("accepted source differs from the picked one");
    chk_ctx_save: assert property (@(posedge mclk) disable iff (rst)
        gen_accepted |-> (saved_status_copy == $past(sr_r) && sr_r.bl && sr_r.md && sr_r.rb))
        else $error("context not saved on acceptance");
    chk_nmi_held: assert property (@(posedge mclk) disable iff (rst)
        ($past(sr_r.bl) && $past(nmi_accept_blocked)) |-> !nmi_accepted)
        else $error("nonmaskable interrupt taken while held");
    chk_nmi_taken: assert property (@(posedge mclk) disable iff (rst)
        (nmi_req && !nmi_accept_blocked && !por_cond && !man_cond && !gen_any)
        |=> nmi_accepted)
        else $error("nonmaskable interrupt not taken");
    chk_irq_taken: assert property (@(posedge mclk) disable iff (rst)
        (irq_req && !sr_r.bl && !por_cond && !man_cond && !gen_any && !nmi_req)
        |=> irq_accepted)
        else $error("pending interrupt not taken after block bit cleared");
    chk_irq_code: assert property (@(posedge mclk) disable iff (rst)
        (irq_accepted || nmi_accepted) |-> (interrupt_event_code == $past(irq_code)
            && $stable(exception_event_code)))
        else $error("interrupt code in the wrong register");
    chk_gen_code: assert property (@(posedge mclk) disable iff (rst)
        gen_accepted |-> $stable(interrupt_event_code))
        else $error("general exception touched interrupt code");

    // Picker: nothing valid is older than the pick; equal ages fall to rank
    for (genvar g = 0; g < NSRC; g++) begin : g_order
        chk_pick_age: assert property (@(posedge mclk) disable iff (rst)
            gen_req[g].valid |-> (gen_req[gen_sel].valid
                && gen_req[gen_sel].age <= gen_req[g].age))
            else $error("later instruction picked before earlier one");
        chk_pick_rank: assert property (@(posedge mclk) disable iff (rst)
            (gen_req[g].valid && gen_req[g].age == gen_req[gen_sel].age)
            |-> gen_req[gen_sel].rank <= gen_req[g].rank)
            else $error("lower ranked source picked on equal age");
    end
endmodule : exacc_flow
`default_nettype wire

// [exacc_pkg.sv]
// What this block does
// - Rank all exception sources; accept only highest ranked when several coincide.
// - The eight decode-detected exceptions share one equal priority level.
// - General exceptions are accepted in program order, earliest instruction first.
// - With block bit clear, exceptions and interrupts are accepted normally.
// - Non-user-break exception with block bit set becomes manual reset to reset vector.
// - Ordinary interrupt held pending while block bit set, accepted once cleared.
// - Nonmaskable interrupt under block bit is held or accepted per software setting.
// - Return op restores program counter and status word from saved copies.
// - Power-on reset from reset pin low, plus select pin high in one variant.
// - Watchdog overflow with timer mode 1 and reset select 0 gives power-on reset.
// - Power-on reset loads event code 000 and branches to the reset vector.
// - Reset clears vector base, sets privilege, bank, block bits, mask 1111, float enabled.
// - Manual reset from select and reset pins low, or manual pin low with reset high.
// - Watchdog overflow with timer mode 1 and reset select 1 gives manual reset.
// - Manual reset loads event code 020, same initialisation, branches to reset vector.
// - Either reset initialises core and peripherals with the matching defaults.
// - Event code goes to exception register for resets and general, interrupt register otherwise.
package exacc_pkg;
    localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;
    localparam logic [11:0] CODE_POWER_ON = 12'h000;
    localparam logic [11:0] CODE_MANUAL = 12'h020;
    localparam logic [3:0] IMASK_RESET = 4'hF;
    localparam int NSRC = 8;
    localparam int SRC_W = 3;

    typedef struct packed {
        logic md;
        logic rb;
        logic bl;
        logic fd;
        logic [3:0] imask;
    } exacc_sr_t;

    localparam exacc_sr_t SR_RESET = '{md: 1'b1, rb: 1'b1, bl: 1'b1, fd: 1'b0, imask: IMASK_RESET};

    typedef enum logic [1:0] {
        EXACC_RST_NONE = 2'h0,
        EXACC_RST_POWER = 2'h1,
        EXACC_RST_MANUAL = 2'h3
    } exacc_rst_t;

    // One general-exception request: age tag (lower is earlier in program order)
    typedef struct packed {
        logic valid;
        logic [3:0] age;
        logic [2:0] rank;
        logic [11:0] code;
    } exacc_req_t;
endpackage : exacc_pkg

// [exacc_pick.sv]
`timescale 1ns/1ps
`default_nettype none
module exacc_pick
    import exacc_pkg::*;
#(
    parameter int N = NSRC
) (
    input wire exacc_req_t req [N],
    output logic any,
    output logic [SRC_W-1:0] sel
);
    // Earliest in program order first, then lowest rank number
    function automatic logic better(input exacc_req_t a, input exacc_req_t b);
        better = a.valid && (!b.valid || a.age < b.age || (a.age == b.age && a.rank < b.rank));
    endfunction : better

    always_comb begin
        any = 1'b0;
        sel = '0;
        for (int i = 0; i < N; i++) begin
            if (better(req[i], req[sel])) begin
                sel = SRC_W'(i);
            end
            any = any | req[i].valid;
        end
    end
endmodule : exacc_pick
`default_nettype wire

// [exacc_rstsrc.sv]
`timescale 1ns/1ps
`default_nettype none
module exacc_rstsrc
    import exacc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic variant_mrpin,
    input wire logic reset_pin_n,
    input wire logic reset_kind_select_pin,
    input wire logic manual_reset_pin_n,
    output logic rst_pin_n_s,
    output logic sel_s,
    output logic mrst_n_s
);
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
        end else begin
            s1_r <= {reset_pin_n, reset_kind_select_pin, manual_reset_pin_n};
            s2_r <= s1_r;
        end
    end
    // Select pin only meaningful in one variant; the other forces it high
    assign rst_pin_n_s = s2_r[2];
    assign sel_s = variant_mrpin ? 1'b1 : s2_r[1];
    assign mrst_n_s = variant_mrpin ? s2_r[0] : 1'b1;
endmodule : exacc_rstsrc
`default_nettype wire

// [exacc_board.sv]
`timescale 1ns/1ps
`default_nettype none
module exacc_board (
    input wire logic mclk,
    output logic reset_pin_n,
    output logic reset_kind_select_pin,
    output logic manual_reset_pin_n,
    output logic test_port_reset_n,
    output logic wdt_overflow,
    output logic watchdog_timer_mode_bit,
    output logic overflow_reset_select_bit
);
    initial begin
        {reset_pin_n, reset_kind_select_pin, manual_reset_pin_n} = 3'h7;
        {test_port_reset_n, wdt_overflow} = 2'h2;
        {watchdog_timer_mode_bit, overflow_reset_select_bit} = 2'h0;
    end
    task automatic edge1();
        @(posedge mclk);
        #1;
    endtask : edge1
    task automatic power_on();
        edge1();
        reset_kind_select_pin = 1'b1;
        test_port_reset_n = 1'b0;
        reset_pin_n = 1'b0;
    endtask : power_on
    // Select drops while reset is still high, never inside the reset window
    task automatic manual(input logic v);
        edge1();
        if (v) begin
            manual_reset_pin_n = 1'b0;
        end else begin
            reset_kind_select_pin = 1'b0;
            edge1();
            reset_pin_n = 1'b0;
        end
    endtask : manual
    task automatic release_all();
        edge1();
        manual_reset_pin_n = 1'b1;
        edge1();
        reset_pin_n = 1'b1;
        test_port_reset_n = 1'b1;
        edge1();
        reset_kind_select_pin = 1'b1;
    endtask : release_all
    task automatic wdt(input logic mode, input logic sel);
        edge1();
        {watchdog_timer_mode_bit, overflow_reset_select_bit} = {mode, sel};
        wdt_overflow = 1'b1;
        edge1();
        wdt_overflow = 1'b0;
    endtask : wdt
endmodule : exacc_board
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import exacc_pkg::*;
    typedef struct packed {
        logic [2:0] a;
        logic [2:0] b;
        logic [2:0] ra;
        logic [2:0] rb;
        logic [3:0] ga;
        logic [3:0] gb;
        logic [2:0] win;
    } exacc_row_t;
    localparam exacc_sr_t SR_OPEN = '{md: 1'b1, rb: 1'b0, bl: 1'b0, fd: 1'b1, imask: 4'h3};
    localparam exacc_sr_t SR_BLK = '{md: 1'b1, rb: 1'b0, bl: 1'b1, fd: 1'b1, imask: 4'h3};
    // Each row ties either ranks or ages, never both, so no ordering is assumed between them
    exacc_row_t rows [4] = '{'{3'h0, 3'h5, 3'h3, 3'h1, 4'h0, 4'h0, 3'h5},
        '{3'h1, 3'h6, 3'h2, 3'h2, 4'h7, 4'h2, 3'h6}, '{3'h7, 3'h2, 3'h0, 3'h4, 4'h5, 4'h5, 3'h7},
        '{3'h3, 3'h4, 3'h5, 3'h5, 4'h1, 4'h9, 3'h3}};
    logic mclk, rst, variant_mrpin, user_break, irq_req, nmi_req, nmi_accept_blocked;
    logic return_from_exception_op, sw_sr_we, reset_pin_n, reset_kind_select_pin;
    logic manual_reset_pin_n, test_port_reset_n, wdt_overflow, watchdog_timer_mode_bit;
    logic overflow_reset_select_bit, branch_valid, init_core, init_periph_power_on;
    logic init_periph_manual, gen_accepted, irq_accepted, nmi_accepted;
    exacc_req_t gen_req [NSRC];
    exacc_sr_t sw_sr_wdata, processor_status_word, saved_status_copy;
    logic [31:0] cur_pc, exc_offset, vector_base, saved_program_counter, branch_target;
    logic [11:0] irq_code, exception_event_code, interrupt_event_code;
    logic [SRC_W-1:0] accepted_src;
    int err_total = 0;
    int n_checks = 0;
    exacc_flow exacc_flow_inst (.*);
    exacc_board exacc_board_inst (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic step();
        @(posedge mclk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait; a missing branch and an unwanted one both show as a mismatch
    task automatic wait_br(input logic exp);
        int k;
        k = 0;
        while (branch_valid !== 1'b1 && k < 10) begin
            step();
            k++;
        end
        chk("branch_valid", 32'(exp), 32'(branch_valid));
    endtask : wait_br
    task automatic chk_rst(input logic [11:0] code, input logic po);
        wait_br(1'b1);
        chk("event_code", 32'(code), 32'(exception_event_code));
        chk("target", RESET_VECTOR, branch_target);
        chk("status", 32'(SR_RESET), 32'(processor_status_word));
        chk("vector_base", VBR_RESET, vector_base);
        chk("init", {29'h0, 1'b1, po, ~po},
            {29'h0, init_core, init_periph_power_on, init_periph_manual});
    endtask : chk_rst
    task automatic sr_write(input exacc_sr_t v);
        sw_sr_we = 1'b1;
        sw_sr_wdata = v;
        step();
        sw_sr_we = 1'b0;
    endtask : sr_write
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        {rst, variant_mrpin, user_break, irq_req, nmi_req, nmi_accept_blocked} = 6'h20;
        {return_from_exception_op, sw_sr_we, sw_sr_wdata} = '0;
        {cur_pc, exc_offset, irq_code} = {32'h0, 32'h0000_0100, 12'h3C0};
        foreach (gen_req[i]) gen_req[i] = '{1'b0, 4'h0, 3'h0, 12'h400 + 12'(i * 32)};
        repeat (2) step();
        rst = 1'b0;
        chk("status", 32'(SR_RESET), 32'(processor_status_word));
        chk("event_code", 32'(CODE_POWER_ON), 32'(exception_event_code));
        foreach (rows[i]) begin
            sr_write(SR_OPEN);
            cur_pc = 32'h0000_1000 + 32'(i);
            {gen_req[rows[i].a].valid, gen_req[rows[i].a].rank} = {1'b1, rows[i].ra};
            {gen_req[rows[i].b].valid, gen_req[rows[i].b].rank} = {1'b1, rows[i].rb};
            gen_req[rows[i].a].age = rows[i].ga;
            gen_req[rows[i].b].age = rows[i].gb;
            step();
            {gen_req[rows[i].a].valid, gen_req[rows[i].b].valid} = 2'b00;
            chk("gen_accepted", 32'h1, 32'(gen_accepted));
            chk("accepted_src", 32'(rows[i].win), 32'(accepted_src));
            chk("event_code", 32'h400 + 32'(rows[i].win) * 32, 32'(exception_event_code));
            chk("saved_pc", cur_pc, saved_program_counter);
            chk("saved_sr", 32'(SR_OPEN), 32'(saved_status_copy));
            chk("target", VBR_RESET + exc_offset, branch_target);
        end
        sr_write(SR_BLK);
        return_from_exception_op = 1'b1;
        step();
        return_from_exception_op = 1'b0;
        chk("status", 32'(SR_OPEN), 32'(processor_status_word));
        chk("target", 32'h0000_1003, branch_target);
        irq_req = 1'b1;
        gen_req[2].valid = 1'b1;
        step();
        gen_req[2].valid = 1'b0;
        chk("irq_vs_gen", 32'h2, {30'h0, gen_accepted, irq_accepted});
        step();
        wait_br(1'b0);
        sr_write(SR_OPEN);
        wait_br(1'b1);
        chk("irq_accepted", 32'h1, 32'(irq_accepted));
        chk("irq_code", 32'h3C0, 32'(interrupt_event_code));
        chk("event_code", 32'h440, 32'(exception_event_code));
        irq_req = 1'b0;
        {nmi_accept_blocked, nmi_req} = 2'b11;
        step();
        wait_br(1'b0);
        nmi_accept_blocked = 1'b0;
        wait_br(1'b1);
        chk("nmi_accepted", 32'h1, 32'(nmi_accepted));
        nmi_req = 1'b0;
        step();
        {user_break, gen_req[4].valid} = 2'b11;
        step();
        wait_br(1'b0);
        user_break = 1'b0;
        chk_rst(CODE_MANUAL, 1'b0);
        gen_req[4].valid = 1'b0;
        repeat (3) step();
        exacc_board_inst.power_on();
        chk_rst(CODE_POWER_ON, 1'b1);
        exacc_board_inst.release_all();
        repeat (6) step();
        exacc_board_inst.manual(1'b0);
        chk_rst(CODE_MANUAL, 1'b0);
        exacc_board_inst.release_all();
        repeat (6) step();
        for (int m = 0; m < 3; m++) begin
            exacc_board_inst.wdt(m != 0, m == 2);
            if (m == 0) begin
                wait_br(1'b0);
            end else begin
                chk_rst(m == 1 ? CODE_POWER_ON : CODE_MANUAL, m == 1);
            end
            repeat (3) step();
        end
        // Variant is static, so it only changes under reset
        {variant_mrpin, rst} = 2'b11;
        repeat (2) step();
        rst = 1'b0;
        exacc_board_inst.manual(1'b1);
        chk_rst(CODE_MANUAL, 1'b0);
        exacc_board_inst.power_on();
        step();
        // Watchdog manual overflow lands while the power-on condition stands
        exacc_board_inst.wdt(1'b1, 1'b1);
        chk_rst(CODE_POWER_ON, 1'b1);
        exacc_board_inst.release_all();
        repeat (5) step();
        wait_br(1'b0);
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
